// file: core/gpw_pkg.sv
// constants and types shared by the two-port gpio block with wake select
// Notes on behaviour
// - wake select bit: 0 gpio, 1 wake input
// - wake select 8-bit read/write, resets to zero
// - wake input ignores the direction bit
// - pins float in reset/standby, hold in sleep
// - standby pin with pull-up on reads high
// - port5 pull-up on only if input and enabled
// - all pull-ups off after reset
// - port6 latch read: latch if output, else pin
// - port6 output latch resets to zero
// - port6 direction: 1 output, 0 input, resets zero
// - port6 direction write-only, reads all ones
// - port6 pull-up on only if input and enabled
// - port6 pull-up control read/write, resets zero
// - port6 registers at ffd9, ffe9, ff9f
// - port5 read: latch if output, else pin
// - port5 direction: 1 output, 0 input
// - port5 direction and latch only for gpio pins
// - port5 direction write-only, reads all ones
package gpw_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry: register index times four is the byte address
  localparam int unsigned ADDR_W = 18;          // covers index 16'hffe9 * 4
  localparam int unsigned DATA_W = 32;          // axi4-lite data width
  localparam int unsigned IDX_W  = 16;          // width of a register index

  //////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [15:0] IDX_P5_LATCH = 16'hffd8;  // port5_output_latch
  localparam logic [15:0] IDX_P5_DIR   = 16'hffe8;  // port5_direction
  localparam logic [15:0] IDX_P5_PU    = 16'hff9e;  // port5_pullup_enable
  localparam logic [15:0] IDX_P5_WAKE  = 16'hff9b;  // port5_wake_select
  localparam logic [15:0] IDX_P6_LATCH = 16'hffd9;  // port6_output_latch
  localparam logic [15:0] IDX_P6_DIR   = 16'hffe9;  // port6_direction
  localparam logic [15:0] IDX_P6_PU    = 16'hff9f;  // port6_pullup_enable

  //////////////////////////////////////////////////////////////////////////////
  // reset and read-back values, bus responses
  localparam logic [7:0] REG_RESET   = 8'h00;     // every register after reset
  localparam logic [7:0] WO_READBACK = 8'hff;     // write-only registers read this
  localparam logic [1:0] RESP_OKAY   = 2'h0;      // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2;      // unmapped address

  //////////////////////////////////////////////////////////////////////////////
  // operating modes signalled by the mode controller
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_STANDBY,
    MODE_WATCH
  } gpw_mode_e;

endpackage

// file: core/gpw_port.sv
// one 8-bit port: pin drive, pull-up control and low-power pin states
`timescale 1ns/1ps
`default_nettype none
module gpw_port (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire gpw_pkg::gpw_mode_e power_mode,
  input  wire logic [7:0]        direction,
  input  wire logic [7:0]        output_latch,
  input  wire logic [7:0]        pullup_enable,
  input  wire logic [7:0]        wake_select,
  output logic [7:0]             pin_out,
  output logic [7:0]             pin_oe,
  output logic [7:0]             pullup_on
);

  // whole state of the port: what the pins show
  typedef struct packed {
    logic [7:0] out;   // driven level
    logic [7:0] oe;    // drive enable
    logic [7:0] pu;    // pull-up switched on
  } gpw_port_s;

  gpw_port_s st;       // registered state
  gpw_port_s next_st;  // next state
  logic [7:0] gpio;    // pins in general i/o function
  logic [7:0] pu_want; // pull-up as the registers ask

  //////////////////////////////////////////////////////////////////////////////
  // next pin state from the mode and the registers
  always_comb
  begin
    next_st = st;
    gpio    = ~wake_select;
    pu_want = pullup_enable & ~direction;
    case (power_mode)
      gpw_pkg::MODE_SLEEP, gpw_pkg::MODE_SUBSLEEP:
      begin
        next_st = st;
      end
      gpw_pkg::MODE_STANDBY, gpw_pkg::MODE_WATCH:
      begin
        // floating, but an enabled pull-up on an input pin keeps the pin high
        next_st.oe  = 8'h00;
        next_st.out = 8'h00;
        next_st.pu  = pu_want;
      end
      default:
      begin
        // wake pins never drive, whatever the direction bit says
        next_st.oe  = direction & gpio;
        next_st.out = output_latch & direction & gpio;
        next_st.pu  = pu_want;
      end
    endcase
    if (!aresetn)
    begin
      next_st = '0;
    end
  end

  // single state register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  // reset is a level, so it floats the pins before the first edge too
  assign pin_out   = st.out;
  assign pin_oe    = st.oe & {8{aresetn}};
  assign pullup_on = st.pu & {8{aresetn}};

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence active_run;
    power_mode == gpw_pkg::MODE_ACTIVE ##1 power_mode == gpw_pkg::MODE_ACTIVE;
  endsequence

  sequence held_low_power;
    (power_mode == gpw_pkg::MODE_SLEEP) [*2];
  endsequence

  pull_rule_a: assert property (active_run |-> pullup_on == ($past(pullup_enable) & ~$past(direction)))
    else $error("pull-up does not follow direction and enable");

  wake_no_drive_a: assert property (active_run |-> (pin_oe & $past(wake_select)) == 8'h00)
    else $error("wake input pin is driven");

  drive_dir_a: assert property (active_run |-> pin_oe == ($past(direction) & ~$past(wake_select)))
    else $error("drive enable does not follow direction");

  standby_float_a: assert property (power_mode == gpw_pkg::MODE_STANDBY |=>
      pin_oe == 8'h00 && pullup_on == ($past(pullup_enable) & ~$past(direction)))
    else $error("standby pin not floating with pull-up kept");

  sleep_hold_a: assert property (held_low_power |->
      $stable(pin_oe) && $stable(pin_out) && $stable(pullup_on))
    else $error("pin changed during sleep");

endmodule
`default_nettype wire

// file: core/gpw_top.sv
// two 8-bit gpio ports with wake select, axi4-lite register slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module gpw_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [17:0]             awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  // axi4-lite write data
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // axi4-lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read address
  input  wire logic [17:0]             araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  // axi4-lite read data
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // operating mode from the mode controller, same clock
  input  wire gpw_pkg::gpw_mode_e      power_mode,
  // first port pins
  input  wire logic [7:0]              first_port_pin_in,
  output logic [7:0]                   first_port_pin_out,
  output logic [7:0]                   first_port_pin_oe,
  output logic [7:0]                   first_port_pullup_on,
  // second port pins
  input  wire logic [7:0]              second_port_pin_in,
  output logic [7:0]                   second_port_pin_out,
  output logic [7:0]                   second_port_pin_oe,
  output logic [7:0]                   second_port_pullup_on,
  // wake input levels, active low, idle high on gpio pins
  output logic [7:0]                   wake_input_pin
);

  //////////////////////////////////////////////////////////////////////////////
  // whole state of the block
  typedef struct packed {
    logic [7:0]  p5_latch;   // port5_output_latch
    logic [7:0]  p5_dir;     // port5_direction
    logic [7:0]  p5_pu;      // port5_pullup_enable
    logic [7:0]  p5_wake;    // port5_wake_select
    logic [7:0]  p6_latch;   // port6_output_latch
    logic [7:0]  p6_dir;     // port6_direction
    logic [7:0]  p6_pu;      // port6_pullup_enable
    logic [15:0] sync1;      // first pin stage, read only by sync2
    logic [15:0] sync2;      // pin levels safe to use
    logic        aw_held;    // write address taken, waiting
    logic [15:0] aw_idx;     // index of the pending write
    logic        w_held;     // write data taken, waiting
    logic [7:0]  w_data;     // low byte of the pending write
    logic        w_en;       // byte lane 0 was strobed
    logic        bvalid;     // write response pending
    logic [1:0]  bresp;      // write response code
    logic        rvalid;     // read data pending
    logic [31:0] rdata;      // read data
    logic [1:0]  rresp;      // read response code
  } gpw_top_s;

  gpw_top_s   st;            // registered state
  gpw_top_s   next_st;       // next state
  logic [7:0] p5_read;       // port5 read-back value
  logic [7:0] p6_read;       // port6 read-back value
  logic [15:0] ar_idx;       // index of the incoming read
  logic        do_write;     // address and data both here

  //////////////////////////////////////////////////////////////////////////////
  // read-back: output pins show the latch, input pins show the live level
  always_comb
  begin
    p5_read = (st.p5_dir & st.p5_latch) | (~st.p5_dir & st.sync2[7:0]);
    p6_read = (st.p6_dir & st.p6_latch) | (~st.p6_dir & st.sync2[15:8]);
  end

  assign ar_idx   = araddr[17:2];
  assign do_write = st.aw_held && st.w_held && !st.bvalid;

  // a new request is taken only while the previous answer is gone
  assign awready = !st.aw_held && !st.bvalid;
  assign wready  = !st.w_held && !st.bvalid;
  assign arready = !st.rvalid;

  //////////////////////////////////////////////////////////////////////////////
  // next state: pin sync, write channel, read channel
  always_comb
  begin
    next_st       = st;
    // two flops on every pin before any logic looks at it
    next_st.sync1 = {second_port_pin_in, first_port_pin_in};
    next_st.sync2 = st.sync1;

    // address and data may come in either order
    if (awvalid && awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx  = awaddr[17:2];
    end
    if (wvalid && wready)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata[7:0];
      next_st.w_en   = wstrb[0];
    end
    if (st.bvalid && bready)
    begin
      next_st.bvalid = 1'b0;
    end

    // registers are only 8 bits, so lane 0 alone carries a write
    if (do_write)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = gpw_pkg::RESP_OKAY;
      if (st.aw_idx == gpw_pkg::IDX_P5_LATCH)
      begin
        if (st.w_en) next_st.p5_latch = st.w_data;
      end
      else if (st.aw_idx == gpw_pkg::IDX_P5_DIR)
      begin
        if (st.w_en) next_st.p5_dir = st.w_data;
      end
      else if (st.aw_idx == gpw_pkg::IDX_P5_PU)
      begin
        if (st.w_en) next_st.p5_pu = st.w_data;
      end
      else if (st.aw_idx == gpw_pkg::IDX_P5_WAKE)
      begin
        if (st.w_en) next_st.p5_wake = st.w_data;
      end
      else if (st.aw_idx == gpw_pkg::IDX_P6_LATCH)
      begin
        if (st.w_en) next_st.p6_latch = st.w_data;
      end
      else if (st.aw_idx == gpw_pkg::IDX_P6_DIR)
      begin
        if (st.w_en) next_st.p6_dir = st.w_data;
      end
      else if (st.aw_idx == gpw_pkg::IDX_P6_PU)
      begin
        if (st.w_en) next_st.p6_pu = st.w_data;
      end
      else
      begin
        next_st.bresp = gpw_pkg::RESP_SLVERR;         // unmapped: nothing stored
      end
    end

    // read channel
    if (st.rvalid && rready)
    begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = gpw_pkg::RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      if (ar_idx == gpw_pkg::IDX_P5_LATCH)
      begin
        next_st.rdata[7:0] = p5_read;
      end
      else if (ar_idx == gpw_pkg::IDX_P5_DIR)
      begin
        next_st.rdata[7:0] = gpw_pkg::WO_READBACK;
      end
      else if (ar_idx == gpw_pkg::IDX_P5_PU)
      begin
        next_st.rdata[7:0] = st.p5_pu;
      end
      else if (ar_idx == gpw_pkg::IDX_P5_WAKE)
      begin
        next_st.rdata[7:0] = st.p5_wake;
      end
      else if (ar_idx == gpw_pkg::IDX_P6_LATCH)
      begin
        next_st.rdata[7:0] = p6_read;
      end
      else if (ar_idx == gpw_pkg::IDX_P6_DIR)
      begin
        next_st.rdata[7:0] = gpw_pkg::WO_READBACK;
      end
      else if (ar_idx == gpw_pkg::IDX_P6_PU)
      begin
        next_st.rdata[7:0] = st.p6_pu;
      end
      else
      begin
        next_st.rresp = gpw_pkg::RESP_SLVERR;
      end
    end

    // every register returns to its documented reset value
    if (!aresetn)
    begin
      next_st          = '0;
      next_st.p5_latch = gpw_pkg::REG_RESET;
      next_st.p5_dir   = gpw_pkg::REG_RESET;
      next_st.p5_pu    = gpw_pkg::REG_RESET;
      next_st.p5_wake  = gpw_pkg::REG_RESET;
      next_st.p6_latch = gpw_pkg::REG_RESET;
      next_st.p6_dir   = gpw_pkg::REG_RESET;
      next_st.p6_pu    = gpw_pkg::REG_RESET;
    end
  end

  // single state register
  always_ff @(posedge aclk)
  begin
    st <= next_st;
  end

  assign bvalid = st.bvalid;
  assign bresp  = st.bresp;
  assign rvalid = st.rvalid;
  assign rdata  = st.rdata;
  assign rresp  = st.rresp;

  // gpio pins hold the wake line idle high
  assign wake_input_pin = st.sync2[7:0] | ~st.p5_wake;

  //////////////////////////////////////////////////////////////////////////////
  // the two pin drivers; port 6 has no wake function
  gpw_port u_first_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .power_mode    (power_mode),
    .direction     (st.p5_dir),
    .output_latch  (st.p5_latch),
    .pullup_enable (st.p5_pu),
    .wake_select   (st.p5_wake),
    .pin_out       (first_port_pin_out),
    .pin_oe        (first_port_pin_oe),
    .pullup_on     (first_port_pullup_on)
  );

  gpw_port u_second_port (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .power_mode    (power_mode),
    .direction     (st.p6_dir),
    .output_latch  (st.p6_latch),
    .pullup_enable (st.p6_pu),
    .wake_select   (8'h00),
    .pin_out       (second_port_pin_out),
    .pin_oe        (second_port_pin_oe),
    .pullup_on     (second_port_pullup_on)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence read_of(logic [15:0] idx);
    arvalid && arready && ar_idx == idx;
  endsequence

  p6_dir_ones_a: assert property (read_of(gpw_pkg::IDX_P6_DIR) |=> rvalid && rdata == 32'h0000_00ff)
    else $error("port6 direction did not read as ones");

  p5_dir_ones_a: assert property (read_of(gpw_pkg::IDX_P5_DIR) |=> rvalid && rdata == 32'h0000_00ff)
    else $error("port5 direction did not read as ones");

  p6_readback_a: assert property (read_of(gpw_pkg::IDX_P6_LATCH) |=>
      rdata[7:0] == (($past(st.p6_dir) & $past(st.p6_latch)) | (~$past(st.p6_dir) & $past(st.sync2[15:8]))))
    else $error("port6 read-back mixes latch and pin wrongly");

  p5_readback_a: assert property (read_of(gpw_pkg::IDX_P5_LATCH) |=>
      rdata[7:0] == (($past(st.p5_dir) & $past(st.p5_latch)) | (~$past(st.p5_dir) & $past(st.sync2[7:0]))))
    else $error("port5 read-back mixes latch and pin wrongly");

  wake_write_a: assert property (do_write && st.w_en && st.aw_idx == gpw_pkg::IDX_P5_WAKE |=>
      st.p5_wake == $past(st.w_data) && bvalid && bresp == gpw_pkg::RESP_OKAY)
    else $error("wake select write not stored");

  wake_read_a: assert property (read_of(gpw_pkg::IDX_P5_WAKE) |=> rdata[7:0] == $past(st.p5_wake))
    else $error("wake select read-back wrong");

  reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
      st.p6_latch == 8'h00 && st.p6_dir == 8'h00 && st.p6_pu == 8'h00 && st.p5_wake == 8'h00)
    else $error("registers not cleared by reset");

  reset_float_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |->
      first_port_pin_oe == 8'h00 && second_port_pin_oe == 8'h00 && first_port_pullup_on == 8'h00)
    else $error("pins driven or pulled up during reset");

endmodule
`default_nettype wire

// file: sim/gpw_board.sv
// board model for one 8-bit port: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
`default_nettype none
module gpw_board (
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] drive_level,
  output logic [7:0]      pin_in
);
  logic [7:0] float_pat;  // level seen on a pin nobody holds

  ////////////////////////////////////////////////////////////
  // undriven pins wander every cycle so a stale level never passes
  always @(posedge aclk)
  begin
    float_pat <= (float_pat === 8'h5a) ? 8'ha5 : 8'h5a;
  end

  ////////////////////////////////////////////////////////////
  // chip drive wins, then the board, then the pull-up, else floating
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (drive_en[i])
        pin_in[i] = drive_level[i];
      else if (pullup_on[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_pat[i];
    end
  end
endmodule
`default_nettype wire

// file: sim/gpw_top_tb.sv
// self-checking bench for the two-port gpio block with wake select
`timescale 1ns/1ps
`default_nettype none
module gpw_top_tb;
  logic               aclk, aresetn;
  logic [17:0]        awaddr, araddr;
  logic [2:0]         awprot, arprot;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  gpw_pkg::gpw_mode_e power_mode;
  logic [7:0]         p5_in, p5_out, p5_oe, p5_pu, p6_in, p6_out, p6_oe, p6_pu, wake_pin;
  logic [7:0]         p5_den, p5_dlev, p6_den, p6_dlev;  // board drive per port
  int                 failures, total_checks;
  localparam logic [1:0] OK = gpw_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = gpw_pkg::RESP_SLVERR;

  always #20 aclk = ~aclk;  // 25 mhz

  gpw_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .power_mode(power_mode), .first_port_pin_in(p5_in), .first_port_pin_out(p5_out),
    .first_port_pin_oe(p5_oe), .first_port_pullup_on(p5_pu), .second_port_pin_in(p6_in),
    .second_port_pin_out(p6_out), .second_port_pin_oe(p6_oe), .second_port_pullup_on(p6_pu),
    .wake_input_pin(wake_pin));
  gpw_board board5_u (.aclk(aclk), .pin_out(p5_out), .pin_oe(p5_oe), .pullup_on(p5_pu),
    .drive_en(p5_den), .drive_level(p5_dlev), .pin_in(p5_in));
  gpw_board board6_u (.aclk(aclk), .pin_out(p6_out), .pin_oe(p6_oe), .pullup_on(p6_pu),
    .drive_en(p6_den), .drive_level(p6_dlev), .pin_in(p6_in));

  ////////////////////////////////////////////////////////////
  // verdict, comparison and bounded-wait helpers
  task automatic print_verdict();
    if (failures == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n > 100)
    begin
      failures++;
      $display("wrong value at %0t: bus answer never came", $time);
      print_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////
  // axi4-lite master; ready lines stay high, which the bus allows
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] exp);
    int n;
    n = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n <= 100)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
      hang(n);
    end
    chk({6'h0, bresp}, {6'h0, exp}, "write response");
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n <= 100)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
      hang(n);
    end
    chk(rdata[7:0], exp, "read data");
    chk({6'h0, rresp}, {6'h0, er}, "read response");
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    gpw_pkg::gpw_mode_e modes[6];
    logic [7:0]         e_oe[6], e_pu[6], e_out[6];
    modes = '{gpw_pkg::MODE_SLEEP, gpw_pkg::MODE_SUBSLEEP, gpw_pkg::MODE_STANDBY,
              gpw_pkg::MODE_WATCH, gpw_pkg::MODE_SUBACTIVE, gpw_pkg::MODE_ACTIVE};
    e_oe  = '{8'h0f, 8'h0f, 8'h00, 8'h00, 8'hf0, 8'hf0};
    e_pu  = '{8'hf0, 8'hf0, 8'h0f, 8'h0f, 8'h0f, 8'h0f};
    e_out = '{8'h0c, 8'h0c, 8'h00, 8'h00, 8'h30, 8'h30};
    {aclk, aresetn, awaddr, araddr, awprot, arprot, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h1;
    power_mode = gpw_pkg::MODE_ACTIVE;
    {p5_den, p6_den, p5_dlev, p6_dlev} = {8'hff, 8'hff, 8'h00, 8'h00};
    failures = 0;
    total_checks = 0;
    repeat (12) @(posedge aclk);
    chk(p5_oe | p6_oe, 8'h00, "drive in reset");
    chk(p5_pu | p6_pu, 8'h00, "pull-up in reset");
    aresetn <= 1'b1;
    // reset values and write-only registers that read as ones
    rd(gpw_pkg::IDX_P5_WAKE, 8'h00, OK);
    rd(gpw_pkg::IDX_P6_PU, 8'h00, OK);
    rd(gpw_pkg::IDX_P5_PU, 8'h00, OK);
    rd(gpw_pkg::IDX_P6_DIR, 8'hff, OK);
    rd(gpw_pkg::IDX_P5_DIR, 8'hff, OK);
    chk(wake_pin, 8'hff, "wake idle");
    wr(gpw_pkg::IDX_P5_WAKE, 8'ha5, OK);
    rd(gpw_pkg::IDX_P5_WAKE, 8'ha5, OK);
    wr(16'h0123, 8'h77, ERR);
    rd(16'h0123, 8'h00, ERR);
    // port 6: low nibble out, all pull-ups asked for, board drives 5a
    wr(gpw_pkg::IDX_P6_DIR, 8'h0f, OK);
    wr(gpw_pkg::IDX_P6_PU, 8'hff, OK);
    wr(gpw_pkg::IDX_P6_LATCH, 8'h3c, OK);
    p6_dlev <= 8'h5a;
    repeat (4) @(posedge aclk);
    chk(p6_oe, 8'h0f, "p6 drive");
    chk(p6_out, 8'h0c, "p6 out");
    chk(p6_pu, 8'hf0, "p6 pull-up");
    rd(gpw_pkg::IDX_P6_LATCH, 8'h5c, OK);
    rd(gpw_pkg::IDX_P6_DIR, 8'hff, OK);
    rd(gpw_pkg::IDX_P6_PU, 8'hff, OK);
    // lane 0 unstrobed: the bus answers okay but the register keeps its value
    wstrb <= 4'h0;
    wr(gpw_pkg::IDX_P6_PU, 8'h00, OK);
    wstrb <= 4'h1;
    rd(gpw_pkg::IDX_P6_PU, 8'hff, OK);
    // port 5: high nibble wake inputs with direction set anyway
    wr(gpw_pkg::IDX_P5_WAKE, 8'hf0, OK);
    wr(gpw_pkg::IDX_P5_DIR, 8'hff, OK);
    wr(gpw_pkg::IDX_P5_LATCH, 8'hff, OK);
    wr(gpw_pkg::IDX_P5_PU, 8'hff, OK);
    p5_dlev <= 8'h30;
    repeat (4) @(posedge aclk);
    chk(p5_oe, 8'h0f, "p5 drive");
    chk(p5_out, 8'h0f, "p5 out");
    chk(p5_pu, 8'h00, "p5 pull-up");
    chk(wake_pin, 8'h3f, "wake level");
    rd(gpw_pkg::IDX_P5_LATCH, 8'hff, OK);
    wr(gpw_pkg::IDX_P5_DIR, 8'h00, OK);
    repeat (4) @(posedge aclk);
    chk(p5_pu, 8'hff, "p5 pull-up in");
    chk(p5_oe, 8'h00, "p5 drive in");
    chk(wake_pin, 8'h3f, "wake level after direction change");
    rd(gpw_pkg::IDX_P5_LATCH, 8'h30, OK);
    // every power mode; direction flips while asleep, board lets go
    p6_den <= 8'h00;
    for (int i = 0; i < 6; i++)
    begin
      power_mode <= modes[i];
      repeat (3) @(posedge aclk);
      if (i == 0)
        wr(gpw_pkg::IDX_P6_DIR, 8'hf0, OK);
      repeat (4) @(posedge aclk);
      chk(p6_oe, e_oe[i], "mode drive");
      chk(p6_out, e_out[i], "mode out");
      chk(p6_pu, e_pu[i], "mode pull-up");
      chk(p6_in & e_pu[i], e_pu[i], "pulled level");
    end
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(p5_oe | p6_oe, 8'h00, "drive in reset");
    chk(p5_pu | p6_pu, 8'h00, "pull-up in reset");
    aresetn <= 1'b1;
    rd(gpw_pkg::IDX_P5_WAKE, 8'h00, OK);
    wr(gpw_pkg::IDX_P6_DIR, 8'hff, OK);
    rd(gpw_pkg::IDX_P6_LATCH, 8'h00, OK);
    print_verdict();
  end
endmodule
`default_nettype wire
